//--- hw/dma_request_throttle.v
// DMA request throttle: AXI4-Lite control register and request gating
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`include "dma_request_throttle_map.vh"

module dma_request_throttle (
  input  wire        clk_sys,         // System clock, 50 MHz
  input  wire        rst_b,           // Synchronous reset, active low
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output wire        s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output wire        s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [3:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output wire        s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  // Transfer engine side
  input  wire        engine_req,      // Engine has a request to submit
  output wire        engine_ack,      // Request accepted this cycle
  // Enhanced DMA controller side
  output wire        dma_req_valid,   // Request toward the controller
  input  wire        dma_req_ready,   // Controller takes the request
  output wire [1:0]  dma_req_queue,   // Queue receiving the request
  input  wire        dma_req_done,    // One earlier request completed
  output wire        request_stall,   // Stall bit as programmed
  output wire [3:0]  outstanding_limit, // Limit as programmed
  output wire [1:0]  queue_priority   // Priority selector as programmed
);

  ////////////////////////////////////////////////////////////////////////////
  // Control state

  reg        stall;          // Stall bit
  reg [1:0]  prio;           // Queue selector
  reg [3:0]  limit;          // Outstanding limit
  wire [4:0] count;          // Outstanding now
  wire       at_limit;       // Ceiling reached

  // Bus capture state
  reg        aw_held;        // Write address captured
  reg [3:0]  aw_addr;        // Captured write address
  reg        w_held;         // Write data captured
  reg [31:0] w_data;         // Captured write data
  reg [3:0]  w_strb;         // Captured strobes

  // Register addresses held at full width so the word index can be sliced
  // out directly; comparing a shifted four-bit constant against a two-bit
  // field would silently pad one side
  localparam [3:0] CONTROL_ADDR = `DRT_CONTROL_ADDR;  // Control word
  localparam [3:0] STATUS_ADDR  = `DRT_STATUS_ADDR;   // Status word
  localparam [1:0] CONTROL_IDX  = CONTROL_ADDR[3:2];  // Control word index
  localparam [1:0] STATUS_IDX   = STATUS_ADDR[3:2];   // Status word index

  // Decode used by both read and write paths; the low two address bits are
  // ignored, so every access is taken as one aligned word
  function is_control;
    input [3:0] addr;
    begin
      is_control = (addr[3:2] == CONTROL_IDX);
    end
  endfunction

  function is_status;
    input [3:0] addr;
    begin
      is_status = (addr[3:2] == STATUS_IDX);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request gating

  // Nothing new goes out while stalled or at the ceiling; a request already
  // offered may drop if stall rises, which only cancels an offer never taken
  assign dma_req_valid = engine_req && !stall && !at_limit;
  assign engine_ack    = dma_req_valid && dma_req_ready;
  assign dma_req_queue = prio;

  assign request_stall     = stall;
  assign outstanding_limit = limit;
  assign queue_priority    = prio;

  // Completions keep decrementing under stall, so pending work drains
  outstanding_counter u_count (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .submit   (engine_ack),
    .complete (dma_req_done),
    .limit    (limit),
    .count    (count),
    .at_limit (at_limit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write channel

  // Timing of a write, as a master sees it:
  //   edge 0  the later of address and data is captured
  //   edge 1  both halves present, register updated, response raised
  //   edge n  response taken with bready, both readies come back
  // Only one write is ever in flight; a second address or data beat is
  // refused until the response has been taken. This costs two cycles per
  // write against a fully pipelined slave, which control traffic never
  // notices, and keeps the capture logic to two flags.
  //
  // Address and data are taken independently, one each until answered
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  wire do_write = aw_held && w_held;  // Both halves present

  // Capture address and data in either order
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Register update and write response
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      stall        <= `DRT_STALL_RESET;
      prio         <= `DRT_PRIO_RESET;
      limit        <= `DRT_LIMIT_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DRT_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (is_control(aw_addr)) begin
          s_axi_bresp <= `DRT_RESP_OKAY;
          // Only bits 8 and 5..0 are stored; the rest are dropped
          if (w_strb[1]) begin
            stall <= w_data[`DRT_STALL_BIT];
          end
          if (w_strb[0]) begin
            prio  <= w_data[`DRT_PRIO_HI:`DRT_PRIO_LO];
            // Zero is reserved; software must not write it, and the
            // stored zero would simply block all new requests
            limit <= w_data[`DRT_LIMIT_HI:`DRT_LIMIT_LO];
          end
        end else if (is_status(aw_addr)) begin
          s_axi_bresp <= `DRT_RESP_OKAY;  // Status is read-only
        end else begin
          s_axi_bresp <= `DRT_RESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel

  assign s_axi_arready = !s_axi_rvalid;

  // Read data register; reserved bits come back as zero
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DRT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      if (is_control(s_axi_araddr)) begin
        s_axi_rdata <= {23'h000000, stall, 2'h0, prio, limit};
        s_axi_rresp <= `DRT_RESP_OKAY;
      end else if (is_status(s_axi_araddr)) begin
        // Live outstanding count and ceiling flag
        s_axi_rdata <= {26'h0000000, at_limit, count};
        s_axi_rresp <= `DRT_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `DRT_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // dma_request_throttle

//--- hw/outstanding_counter.v
// Counter of requests submitted but not yet completed, with limit check
module outstanding_counter (
  input  wire       clk_sys,   // System clock
  input  wire       rst_b,     // Synchronous reset, active low
  input  wire       submit,    // A request is handed over this cycle
  input  wire       complete,  // The controller reports one request done
  input  wire [3:0] limit,     // Programmed ceiling
  output reg  [4:0] count,     // Requests outstanding now
  output wire       at_limit   // No further request may go out
);

  // Count is five bits so a lowered limit below count never wraps
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      count <= 5'h00;
    end else if (submit && !complete) begin
      count <= count + 5'h01;
    end else if (complete && !submit && (count != 5'h00)) begin
      count <= count - 5'h01;
    end
  end

  // Compare as greater-or-equal, since the limit may drop while busy
  assign at_limit = (count >= {1'b0, limit});

endmodule // outstanding_counter

//--- pkg/dma_request_throttle_map.vh
// Register map, field layout, reset values and sizes of the DMA request throttle
`ifndef DMA_REQUEST_THROTTLE_MAP_VH
`define DMA_REQUEST_THROTTLE_MAP_VH

// Byte addresses on the register bus
`define DRT_CONTROL_ADDR      4'h0
`define DRT_STATUS_ADDR       4'h4
`define DRT_ADDR_W            4

// Control register field positions
`define DRT_STALL_BIT         8
`define DRT_PRIO_HI           5
`define DRT_PRIO_LO           4
`define DRT_LIMIT_HI          3
`define DRT_LIMIT_LO          0

// Reset values of the control fields
`define DRT_STALL_RESET       1'h0
`define DRT_PRIO_RESET        2'h2
`define DRT_LIMIT_RESET       4'h4

// Queue priority codes
`define DRT_PRIO_URGENT       2'h0
`define DRT_PRIO_HIGH         2'h1
`define DRT_PRIO_MEDIUM       2'h2
`define DRT_PRIO_LOW          2'h3

// Mask of writable control bits
`define DRT_CONTROL_MASK      32'h0000013F

// AXI response codes
`define DRT_RESP_OKAY         2'h0
`define DRT_RESP_SLVERR       2'h2

`endif

//--- verification/dma_queue_model.sv
// Behavioural model of the DMA controller request queues
module dma_queue_model (
  input  logic clk_sys,
  input  logic rst_b,
  input  logic dma_req_valid,
  input  logic hold,          // Testbench withholds completions
  output logic dma_req_ready,
  output logic dma_req_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int         seed = 26; // Fixed seed keeps runs repeatable
  logic [4:0] pend;      // Taken but not completed
  logic [4:0] p;
  // Random acceptance; a completion only for something really taken
  always @(posedge clk_sys) begin
    p = pend + 5'(dma_req_valid && dma_req_ready) - 5'(dma_req_done);
    pend <= rst_b ? p : 5'h00;
    dma_req_ready <= rst_b && $random(seed) % 2 == 0;
    dma_req_done <= rst_b && !hold && p != 5'h00 && $random(seed) % 2 == 0;
  end
endmodule // dma_queue_model

//--- verification/dma_request_throttle_sva.sv
// Port assertions of the DMA request throttle
`include "dma_request_throttle_map.vh"
module dma_request_throttle_sva (
  input logic        clk_sys,
  input logic        rst_b,
  input logic        engine_req,
  input logic        engine_ack,
  input logic        dma_req_valid,
  input logic        dma_req_ready,
  input logic        dma_req_done,
  input logic [1:0]  dma_req_queue,
  input logic        request_stall,
  input logic [1:0]  queue_priority,
  input logic [3:0]  outstanding_limit,
  input logic        s_axi_bvalid,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic [4:0] cnt; // Own tally, kept apart from the design's counter
  // Taken requests up, completions down, never below zero
  always @(posedge clk_sys)
    if (!rst_b) cnt <= 5'h00;
    else cnt <= cnt + 5'(dma_req_valid && dma_req_ready) - 5'(dma_req_done && cnt != 5'h00);
  ////////////////////////////////////////////////////////////////////////////
  a_stall_blocks: assert property (request_stall |-> !dma_req_valid)
    else $error("request offered while stalled");
  a_open_offers: assert property (engine_req && !request_stall && cnt < outstanding_limit |-> dma_req_valid)
    else $error("request held back without cause");
  a_queue_follows: assert property (dma_req_valid |-> dma_req_queue == queue_priority)
    else $error("request sent to wrong queue");
  a_limit_kept: assert property (dma_req_valid |-> cnt < {1'b0, outstanding_limit})
    else $error("request offered at the limit");
  a_reset_fields: assert property ($rose(rst_b) |-> !request_stall && queue_priority == `DRT_PRIO_RESET
    && outstanding_limit == `DRT_LIMIT_RESET)
    else $error("control fields not at defaults");
  a_write_only: assert property ($changed({request_stall, queue_priority, outstanding_limit})
    |-> $rose(s_axi_bvalid))
    else $error("control fields moved without a write");
  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:9] == 23'h0 && s_axi_rdata[7:6] == 2'h0)
    else $error("reserved read data not zero");
  a_done_reopens: assert property (cnt == {1'b0, outstanding_limit} && dma_req_done && !request_stall
    |=> dma_req_valid || !engine_req || request_stall || $changed(outstanding_limit))
    else $error("completion did not free a slot");
  a_ack_pairs: assert property (engine_ack == (dma_req_valid && dma_req_ready))
    else $error("engine ack does not match a taken request");
  c_submit: cover property (dma_req_valid && dma_req_ready);
  c_stalled: cover property (request_stall && engine_req);
  c_full: cover property (engine_req && !request_stall && cnt == {1'b0, outstanding_limit});
endmodule // dma_request_throttle_sva
bind dma_request_throttle dma_request_throttle_sva u_sva (.*);

//--- verification/dma_request_throttle_test.sv
// Self-checking testbench of the DMA request throttle
`include "dma_request_throttle_map.vh"
module dma_request_throttle_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, hold = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, engine_req = 0; // Response readies stay up
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, lim;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, dma_req_queue, queue_priority, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, engine_ack;
  logic dma_req_valid, dma_req_ready, dma_req_done, request_stall;
  logic [3:0] outstanding_limit;
  int seed = 26, fail_count = 0, n_compared = 0, cyc = 0;
  dma_request_throttle DUT (.*);
  dma_queue_model far_end (.*);
  always #10 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] ctl(input logic s, input logic [1:0] q, input logic [3:0] l);
    return {23'h0, s, 2'h0, q, l};
  endfunction
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task stop_test();
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, well above the roughly 1100 cycles the run needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1;
    rd(`DRT_CONTROL_ADDR);
    chk(d, ctl(`DRT_STALL_RESET, `DRT_PRIO_RESET, `DRT_LIMIT_RESET));
    wr(`DRT_CONTROL_ADDR, 32'hFFFFFFFF);
    chk(r, `DRT_RESP_OKAY);
    rd(`DRT_CONTROL_ADDR);
    chk(d, `DRT_CONTROL_MASK);
    rd(4'h8);
    chk({d, r}, {32'h0, `DRT_RESP_SLVERR});
    engine_req <= 1;
    for (int q = 0; q < 4; q++) begin
      wr(`DRT_CONTROL_ADDR, ctl(1, 2'(q), 4'h4));
      chk({dma_req_valid, dma_req_queue}, {1'b0, 2'(q)});
    end
    for (int i = 0; i < 8; i++) begin
      lim = 4'(1 + {$random(seed)} % 15);
      hold <= 1;
      wr(`DRT_CONTROL_ADDR, ctl(0, 2'h2, lim) | ({$random(seed)} & ~`DRT_CONTROL_MASK));
      repeat (60) @(posedge clk_sys);
      rd(`DRT_STATUS_ADDR);
      chk(d, {26'h0, 2'b10, lim});
      wr(`DRT_CONTROL_ADDR, ctl(1, 2'h2, lim));
      rd(`DRT_STATUS_ADDR);
      chk(d, {26'h0, 2'b10, lim});
      hold <= 0;
      repeat (60) @(posedge clk_sys);
      rd(`DRT_STATUS_ADDR);
      chk(d, 32'h0);
    end
    stop_test();
  end
endmodule // dma_request_throttle_test
